// File: hdl/acm_control.v
// Converter controller: APB registers, mode control and sequencer
// Function
// RULE1: Command soft reset bit one returns the whole controller to power-on state; the trigger synchroniser stages are cleared by rst only.
// RULE2: Command start bit one launches a conversion of enabled channels.
// RULE3: Hardware trigger disabled means only software start launches conversions.
// RULE4: Hardware trigger enabled starts a sequence on each selected source event.
// RULE5: Source values one to six pick timer outputs zero to five.
// RULE6: Resolution bit clear gives 10-bit results, set gives 8-bit.
// RULE7: Sleep clear keeps core and reference powered between conversions.
// RULE8: Sleep set powers core off between conversions, up again each time.
// RULE9: Free-run set converts continuously without any trigger.
// RULE10: Software keeps free-run clear while averaging ratio is nonzero.
// RULE11: Converter clock is peripheral clock over twice divider plus one.
// RULE12: Warm-up code selects 0..112 or 512..960 converter clock periods.
// RULE13: Tracking lasts the tracking field plus one converter clock periods.
// RULE14: Custom order clear converts enabled channels in ascending index order.
// RULE15: Custom order set follows sequence slots, repeats allowed.
// RULE16: Mode register writes are dropped while write lock is enabled.
// RULE17: Unmapped offsets are reserved and have no function.
// RULE18: Locked write sets violation flag and source; reading status clears it.
// RULE19: Averaging ratio one uses four samples, two uses sixteen.
// RULE20: Mode fields sit at their fixed documented bit positions.
// RULE21: Write-only registers and reserved bits read zero; reserved writes ignored.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "acm_regs.vh"
module acm_control #(
  parameter NCH = 8
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [5:0] timerTrigIn,
  output reg convClk,
  output reg corePowerOn,
  output reg convStart,
  output reg [2:0] convChannel,
  output reg convLowRes,
  output reg trackActive,
  input wire convDone,
  input wire [9:0] convData
);
// ----------------------------------------------------------------
// Register state
// ----------------------------------------------------------------
reg [31:0] cfg_reg;
reg [31:0] seq_reg;
reg [7:0] chEn_reg;
reg [31:0] ext_reg;
reg [31:0] thCfg_reg;
reg [31:0] thWin_reg;
reg [31:0] cmpWin_reg;
reg [31:0] tune_reg;
reg [31:0] wlCfg_reg;
reg wlViol_reg;
reg [7:0] wlSrc_reg;
reg [15:0] latest_reg;
reg [15:0] result_reg [0:NCH-1];
reg [7:0] eoc_reg;
reg drdy_reg;
reg [7:0] imr_reg;
// Synchronised trigger pins
reg [5:0] trigS1_reg;
reg [5:0] trigS2_reg;
reg [5:0] trigS3_reg;
wire wrEn = psel && penable && pwrite;
wire rdEn = psel && penable && !pwrite;
wire softRst = wrEn && paddr == `ACM_OFF_CMD && pwdata[`ACM_CMD_SRST];
wire anyRst = rst || softRst; // RULE1
wire locked = wlCfg_reg[`ACM_WL_EN];
assign pready = 1'b1;
assign pslverr = 1'b0;
// Write-protected targets: everything configurable except lock itself and the interrupt mask set/clear
wire isProt = paddr == `ACM_OFF_CFG || paddr == `ACM_OFF_SEQ ||
  paddr == `ACM_OFF_CHSET || paddr == `ACM_OFF_CHCLR ||
  paddr == `ACM_OFF_THCFG || paddr == `ACM_OFF_THWIN ||
  paddr == `ACM_OFF_EXTCFG || paddr == `ACM_OFF_CMPWIN ||
  paddr == `ACM_OFF_TUNE;
wire wrOk = wrEn && !(locked && isProt); // RULE16
// Mode fields
wire hw_trigger_enable = cfg_reg[`ACM_CFG_HW_TRIGGER_ENABLE];
wire [2:0] trigger_source_select = cfg_reg[`ACM_CFG_TRIGGER_SOURCE_SELECT_HI:`ACM_CFG_TRIGGER_SOURCE_SELECT_LO];
wire resolution_select = cfg_reg[`ACM_CFG_RES];
wire sleepEn = cfg_reg[`ACM_CFG_SLEEP];
wire continuous_conversion = cfg_reg[`ACM_CFG_FREE];
wire [7:0] divVal = cfg_reg[`ACM_CFG_DIV_HI:`ACM_CFG_DIV_LO];
wire [3:0] warmSel = cfg_reg[`ACM_CFG_WARM_HI:`ACM_CFG_WARM_LO];
wire [3:0] trackVal = cfg_reg[`ACM_CFG_TRACK_HI:`ACM_CFG_TRACK_LO];
wire custom_order_enable = cfg_reg[`ACM_CFG_CUSTOM_ORDER_ENABLE];
wire [2:0] averaging_ratio = ext_reg[`ACM_EXT_OSR_HI:`ACM_EXT_OSR_LO];
// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
always @(posedge clk) begin
  if (anyRst) begin
    cfg_reg <= `ACM_RST_ZERO;
    seq_reg <= `ACM_RST_ZERO;
    chEn_reg <= 8'h00;
    ext_reg <= `ACM_RST_ZERO;
    thCfg_reg <= `ACM_RST_ZERO;
    thWin_reg <= `ACM_RST_ZERO;
    cmpWin_reg <= `ACM_RST_ZERO;
    tune_reg <= `ACM_RST_ZERO;
    wlCfg_reg <= `ACM_RST_ZERO;
    imr_reg <= 8'h00;
  end else if (wrOk) begin
    case (paddr)
      `ACM_OFF_CFG: cfg_reg <= pwdata & `ACM_CFG_MASK; // RULE20 RULE21
      `ACM_OFF_SEQ: seq_reg <= pwdata;
      `ACM_OFF_CHSET: chEn_reg <= chEn_reg | (pwdata[7:0] & `ACM_CH_MASK);
      `ACM_OFF_CHCLR: chEn_reg <= chEn_reg & ~pwdata[7:0];
      `ACM_OFF_EXTCFG: ext_reg <= pwdata;
      `ACM_OFF_THCFG: thCfg_reg <= pwdata;
      `ACM_OFF_THWIN: thWin_reg <= pwdata;
      `ACM_OFF_CMPWIN: cmpWin_reg <= pwdata;
      `ACM_OFF_TUNE: tune_reg <= pwdata;
      `ACM_OFF_WLCFG: wlCfg_reg <= pwdata;
      `ACM_OFF_IRQSET: imr_reg <= imr_reg | pwdata[7:0];
      `ACM_OFF_IRQCLR: imr_reg <= imr_reg & ~pwdata[7:0];
      default: ; // RULE17
    endcase
  end
end
// Violation flag: a new violation wins over the clearing read
always @(posedge clk) begin
  if (anyRst) begin
    wlViol_reg <= 1'b0;
    wlSrc_reg <= 8'h00;
  end else if (wrEn && locked && isProt) begin
    wlViol_reg <= 1'b1; // RULE18
    wlSrc_reg <= paddr[9:2];
  end else if (rdEn && paddr == `ACM_OFF_WLFLAGS) begin
    wlViol_reg <= 1'b0; // RULE18
  end
end
// ----------------------------------------------------------------
// Converter clock divider
// ----------------------------------------------------------------
reg [7:0] divCnt_reg;
reg tick;
always @(posedge clk) begin
  if (anyRst) begin
    divCnt_reg <= 8'h00;
    convClk <= 1'b0;
    tick <= 1'b0;
  end else if (divCnt_reg >= divVal) begin
    // Half period of divVal+1 clocks gives f/((div+1)*2)
    divCnt_reg <= 8'h00;
    convClk <= ~convClk; // RULE11
    tick <= ~convClk;
  end else begin
    divCnt_reg <= divCnt_reg + 8'h01;
    tick <= 1'b0;
  end
end
// ----------------------------------------------------------------
// Trigger selection
// ----------------------------------------------------------------
always @(posedge clk) begin
  if (rst) begin
    trigS1_reg <= 6'h00;
    trigS2_reg <= 6'h00;
    trigS3_reg <= 6'h00;
  end else begin
    trigS1_reg <= timerTrigIn;
    trigS2_reg <= trigS1_reg;
    trigS3_reg <= trigS2_reg;
  end
end
wire [5:0] trigRise = trigS2_reg & ~trigS3_reg;
reg hwEvent;
always @* begin
  hwEvent = 1'b0;
  if (trigger_source_select >= 3'd1 && trigger_source_select <= 3'd6)
    hwEvent = trigRise[trigger_source_select - 3'd1]; // RULE5
end
wire swStart = wrEn && paddr == `ACM_OFF_CMD && pwdata[`ACM_CMD_START];
wire trigger = swStart || (hw_trigger_enable && hwEvent); // RULE2 RULE3 RULE4
// ----------------------------------------------------------------
// Warm-up table in converter clock periods
// ----------------------------------------------------------------
reg [9:0] warmPer;
always @* begin
  case (warmSel) // RULE12
    4'd0: warmPer = 10'd0;
    4'd1: warmPer = 10'd8;
    4'd2: warmPer = 10'd16;
    4'd3: warmPer = 10'd24;
    4'd4: warmPer = 10'd64;
    4'd5: warmPer = 10'd80;
    4'd6: warmPer = 10'd96;
    4'd7: warmPer = 10'd112;
    default: warmPer = 10'd512 + {warmSel[2:0], 6'd0};
  endcase
end
// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
localparam S_IDLE = 3'd0;
localparam S_WARM = 3'd1;
localparam S_TRACK = 3'd2;
localparam S_CONV = 3'd3;
localparam S_NEXT = 3'd4;
reg [2:0] state_reg;
reg [9:0] cnt_reg;
reg [3:0] slot_reg;
reg pending_reg;
reg [4:0] avgCnt_reg;
reg [13:0] acc_reg;
reg found;
reg [3:0] foundSlot;
integer i;
// Next enabled slot at or after slot_reg; channel index or custom slot
always @* begin
  found = 1'b0;
  foundSlot = 4'd0;
  for (i = NCH - 1; i >= 0; i = i - 1) begin
    if (i >= slot_reg && chEn_reg[i]) begin
      found = 1'b1; // RULE14
      foundSlot = i[3:0];
    end
  end
end
wire [2:0] slotChan = custom_order_enable ? seq_reg[foundSlot*4 +: 3] : foundSlot[2:0];
// Averaging sample counts
wire [4:0] avgN = (averaging_ratio == 3'd1) ? 5'd4 : (averaging_ratio == 3'd2) ? 5'd16 : 5'd1;
wire [1:0] avgSh = (averaging_ratio == 3'd1) ? 2'd1 : (averaging_ratio == 3'd2) ? 2'd2 : 2'd0;
wire [13:0] accSum = acc_reg + {4'd0, convData};
wire [9:0] sample = resolution_select ? {2'b00, convData[9:2]} : convData; // RULE6
// Averaged word keeps the extra resolution bits that the shift leaves
wire [13:0] avgShift = accSum >> avgSh;
wire [15:0] resultWord = (averaging_ratio == 3'd0) ? {6'd0, sample} : {2'd0, avgShift};
always @(posedge clk) begin
  if (anyRst) begin
    state_reg <= S_IDLE;
    cnt_reg <= 10'd0;
    slot_reg <= 4'd0;
    pending_reg <= 1'b0;
    corePowerOn <= 1'b0;
    convStart <= 1'b0;
    convChannel <= 3'd0;
    convLowRes <= 1'b0;
    trackActive <= 1'b0;
    avgCnt_reg <= 5'd0;
    acc_reg <= 14'd0;
    latest_reg <= 16'h0000;
    eoc_reg <= 8'h00;
    drdy_reg <= 1'b0;
  end else begin
    convStart <= 1'b0;
    convLowRes <= resolution_select;
    if (trigger && state_reg != S_IDLE)
      pending_reg <= 1'b1;
    // Read clears the ready flag first so a result in the same cycle wins
    if (rdEn && paddr == `ACM_OFF_LATEST)
      drdy_reg <= 1'b0;
    case (state_reg)
      S_IDLE: begin
        corePowerOn <= !sleepEn; // RULE7 RULE8
        slot_reg <= 4'd0;
        if ((trigger || pending_reg || continuous_conversion) && |chEn_reg) begin // RULE9
          pending_reg <= 1'b0;
          corePowerOn <= 1'b1;
          cnt_reg <= sleepEn ? warmPer : 10'd0; // RULE8
          state_reg <= S_WARM;
        end
      end
      // Warm-up and tracking step on converter ticks only, so each spans whole periods
      S_WARM: begin
        if (tick && cnt_reg <= 10'd1) begin
          if (found) begin
            convChannel <= slotChan; // RULE15
            cnt_reg <= {6'd0, trackVal} + 10'd1; // RULE13
            trackActive <= 1'b1;
            state_reg <= S_TRACK;
          end else begin
            state_reg <= S_IDLE;
          end
        end else if (tick) begin
          cnt_reg <= cnt_reg - 10'd1;
        end
      end
      S_TRACK: begin
        if (tick && cnt_reg <= 10'd1) begin
          trackActive <= 1'b0;
          convStart <= 1'b1;
          cnt_reg <= `ACM_CONV_CYCLES;
          state_reg <= S_CONV;
        end else if (tick) begin
          cnt_reg <= cnt_reg - 10'd1;
        end
      end
      S_CONV: begin
        if (convDone) begin
          if (avgCnt_reg + 5'd1 >= avgN) begin // RULE19
            latest_reg <= resultWord;
            result_reg[convChannel] <= resultWord;
            eoc_reg[convChannel] <= 1'b1;
            drdy_reg <= 1'b1;
            avgCnt_reg <= 5'd0;
            acc_reg <= 14'd0;
          end else begin
            avgCnt_reg <= avgCnt_reg + 5'd1;
            acc_reg <= accSum;
          end
          state_reg <= S_NEXT;
        end
      end
      S_NEXT: begin
        slot_reg <= foundSlot + 4'd1;
        cnt_reg <= 10'd0;
        state_reg <= ({28'd0, foundSlot} == NCH - 1) ? S_IDLE : S_WARM;
      end
      default: state_reg <= S_IDLE;
    endcase
  end
end
// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @(posedge clk) begin
  if (anyRst) begin
    prdata <= 32'h00000000;
  end else if (psel && !penable && !pwrite) begin
    case (paddr)
      `ACM_OFF_CFG: prdata <= cfg_reg;
      `ACM_OFF_SEQ: prdata <= seq_reg;
      `ACM_OFF_CHSTATE: prdata <= {24'd0, chEn_reg};
      `ACM_OFF_LATEST: prdata <= {16'd0, latest_reg};
      `ACM_OFF_IRQMASK: prdata <= {24'd0, imr_reg};
      `ACM_OFF_EVENTS: prdata <= {7'd0, drdy_reg, 16'd0, eoc_reg};
      `ACM_OFF_THCFG: prdata <= thCfg_reg;
      `ACM_OFF_THWIN: prdata <= thWin_reg;
      `ACM_OFF_EXTCFG: prdata <= ext_reg;
      `ACM_OFF_CMPWIN: prdata <= cmpWin_reg;
      `ACM_OFF_TUNE: prdata <= tune_reg;
      `ACM_OFF_WLCFG: prdata <= wlCfg_reg;
      `ACM_OFF_WLFLAGS: prdata <= {16'd0, wlSrc_reg, 7'd0, wlViol_reg};
      default: begin
        if (paddr >= `ACM_OFF_RES0 && paddr <= `ACM_OFF_RES7 &&
            paddr[1:0] == 2'b00)
          prdata <= {16'd0, result_reg[paddr[4:2] - 3'd4]};
        else
          prdata <= 32'h00000000; // RULE21 RULE17
      end
    endcase
  end
end
endmodule
`default_nettype wire

// File: hdl/acm_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef ACM_REGS_VH
`define ACM_REGS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ACM_OFF_CMD 12'h000
`define ACM_OFF_CFG 12'h004
`define ACM_OFF_SEQ 12'h008
`define ACM_OFF_CHSET 12'h010
`define ACM_OFF_CHCLR 12'h014
`define ACM_OFF_CHSTATE 12'h018
`define ACM_OFF_LATEST 12'h020
`define ACM_OFF_IRQSET 12'h024
`define ACM_OFF_IRQCLR 12'h028
`define ACM_OFF_IRQMASK 12'h02c
`define ACM_OFF_EVENTS 12'h030
`define ACM_OFF_THCFG 12'h034
`define ACM_OFF_THWIN 12'h038
`define ACM_OFF_OVER 12'h03c
`define ACM_OFF_EXTCFG 12'h040
`define ACM_OFF_CMPWIN 12'h044
`define ACM_OFF_RES0 12'h050
`define ACM_OFF_RES7 12'h06c
`define ACM_OFF_TUNE 12'h094
`define ACM_OFF_WLCFG 12'h0e4
`define ACM_OFF_WLFLAGS 12'h0e8
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACM_CMD_SRST 0
`define ACM_CMD_START 1
`define ACM_CFG_HW_TRIGGER_ENABLE 0
`define ACM_CFG_TRIGGER_SOURCE_SELECT_LO 1
`define ACM_CFG_TRIGGER_SOURCE_SELECT_HI 3
`define ACM_CFG_RES 4
`define ACM_CFG_SLEEP 5
`define ACM_CFG_FREE 7
`define ACM_CFG_DIV_LO 8
`define ACM_CFG_DIV_HI 15
`define ACM_CFG_WARM_LO 16
`define ACM_CFG_WARM_HI 19
`define ACM_CFG_TRACK_LO 24
`define ACM_CFG_TRACK_HI 27
`define ACM_CFG_CUSTOM_ORDER_ENABLE 31
`define ACM_CFG_MASK 32'h8f0fffbf
`define ACM_CH_MASK 8'hcf
`define ACM_EXT_OSR_LO 16
`define ACM_EXT_OSR_HI 18
`define ACM_WL_EN 0
`define ACM_WLF_VIOL 0
`define ACM_WLF_SRC_LO 8
`define ACM_WLF_SRC_HI 15
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ACM_RST_ZERO 32'h00000000
`define ACM_CONV_CYCLES 10'd20
`endif

// File: sim/acm_control_sva.sv
// Port checker for the converter controller
`timescale 1ns/1ps
`default_nettype none
`include "acm_regs.vh"
module acm_control_sva (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire corePowerOn,
  input wire convStart,
  input wire convLowRes,
  input wire trackActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic lock_reg;
  logic [31:0] cfg_reg;
  wire wrDone = psel && penable && pwrite && pready;
  wire rdSetup = psel && !penable && !pwrite;
  wire srst = wrDone && paddr == 12'h000 && pwdata[0];
  // Shadow of lock bit and mode word; soft reset clears both
  always @(posedge clk) begin
    if (rst || srst) begin
      lock_reg <= 1'b0;
      cfg_reg <= 32'h00000000;
    end else if (wrDone) begin
      if (paddr == 12'h0e4) lock_reg <= pwdata[0];
      if (paddr == 12'h004 && !lock_reg) cfg_reg <= pwdata & `ACM_CFG_MASK;
    end
  end
  ready_high_a: assert property (pready && !pslverr)
    else $error("bus answer not immediate");
  reset_quiet_a: assert property ($fell(rst) |-> !convStart &&
    !trackActive && !corePowerOn) else $error("outputs live after reset");
  srst_quiet_a: assert property (srst |=> !convStart &&
    !trackActive && !corePowerOn) else $error("soft reset ignored");
  wo_read_a: assert property (rdSetup && (paddr == 12'h000 ||
    paddr == 12'h00c || paddr == 12'h070) |=> prdata == 32'h00000000)
    else $error("empty place reads nonzero");
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("start longer than one cycle");
  start_tracked_a: assert property (convStart |-> $past(trackActive))
    else $error("start without tracking");
  powered_conv_a: assert property (trackActive || convStart |-> corePowerOn)
    else $error("converting while powered off");
  cfg_read_a: assert property (rdSetup && paddr == 12'h004 |=>
    prdata == cfg_reg) else $error("mode word mismatch");
  resolution_select_a: assert property (convStart |-> convLowRes == cfg_reg[4])
    else $error("resolution not applied");
endmodule
bind acm_control acm_control_sva chk_u (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .corePowerOn(corePowerOn), .convStart(convStart),
  .convLowRes(convLowRes), .trackActive(trackActive));
`default_nettype wire

// File: sim/acm_core_model.sv
// Behavioural analog core answering each conversion request
`timescale 1ns/1ps
`default_nettype none
module acm_core_model (
  input wire logic clk,
  input wire logic convStart,
  input wire logic [2:0] convChannel,
  input wire logic [7:0] lat,
  output var logic convDone,
  output var logic [9:0] convData
);
  int n = 0;
  initial convDone = 1'b0;
  initial convData = 10'h000;
  // Answer after lat cycles; data toggles when not valid so no stale match
  always @(posedge clk) begin
    convDone <= 1'b0;
    convData <= ~convData;
    if (convStart) n <= lat;
    else if (n > 0) n <= n - 1;
    if (n == 1) begin
      convDone <= 1'b1;
      convData <= {convChannel, 7'h2a};
    end
  end
endmodule
`default_nettype wire

// File: sim/adc_control_mode_registers_bench.sv
// Self-checking bench for the converter controller
`timescale 1ns/1ps
`default_nettype none
`include "acm_regs.vh"
module adc_control_mode_registers_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd, mcfg;
  logic [5:0] timerTrigIn = 6'h00;
  logic [7:0] lat = 8'h01;
  wire pready, pslverr, convClk, corePowerOn, convStart, convLowRes;
  wire trackActive, convDone;
  wire [31:0] prdata;
  wire [2:0] convChannel;
  wire [9:0] convData;
  int error_cnt = 0, checks = 0, i, k;
  logic [2:0] q[$];
  logic [11:0] offs [10] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h018,
    12'h020, 12'h030, 12'h070, 12'h0e4, 12'h0e8};
  realtime t;
  always #25 clk = ~clk;
  acm_control dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timerTrigIn(timerTrigIn),
    .convClk(convClk), .corePowerOn(corePowerOn), .convStart(convStart),
    .convChannel(convChannel), .convLowRes(convLowRes),
    .trackActive(trackActive), .convDone(convDone), .convData(convData));
  acm_core_model core_u (.clk(clk), .convStart(convStart),
    .convChannel(convChannel), .lat(lat), .convDone(convDone),
    .convData(convData));
  // Reference queue of requested channels
  always @(posedge clk) if (convStart === 1'b1) q.push_back(convChannel);
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Master holds the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task waitq(input int n);
    for (i = 0; i < 4000 && q.size() < n; i++) @(posedge clk);
    cmp(q.size(), n);
  endtask
  task go;
    q.delete();
    apb(1'b1, 12'h000, 32'h2);
  endtask
  task pulse(input logic [5:0] b);
    timerTrigIn <= b;
    repeat (4) @(posedge clk);
    timerTrigIn <= 6'h00;
  endtask
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: the whole run needs well under this span
  initial begin
    #(60000 * 50);
    error_cnt++;
    finish_test();
  end
  initial begin
    k = $urandom(57736);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[j]) rdc(offs[j], 32'h0);
    mcfg = $urandom & 32'hffffff7e;
    apb(1'b1, 12'h004, mcfg);
    rdc(12'h004, mcfg & `ACM_CFG_MASK);
    apb(1'b1, 12'h010, 32'hffffffff);
    apb(1'b1, 12'h014, 32'h000000c2);
    rdc(12'h018, 32'h0000000d);
    // Locked write is dropped and the violation is recorded
    apb(1'b1, 12'h0e4, 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    rdc(12'h004, mcfg & `ACM_CFG_MASK);
    rdc(12'h0e8, 32'h00000101);
    apb(1'b0, 12'h0e8, 32'h0);
    cmp(rd & 32'h1, 32'h0);
    apb(1'b1, 12'h0e4, 32'h0);
    // Index order, then slot order with a repeated channel, slow core
    apb(1'b1, 12'h004, 32'h00000010);
    go();
    waitq(3);
    cmp({q[0], q[1], q[2]}, {3'd0, 3'd2, 3'd3});
    lat <= 8'd30;
    apb(1'b1, 12'h008, 32'h00007373);
    apb(1'b1, 12'h004, 32'h80000000);
    go();
    waitq(3);
    cmp({q[0], q[1], q[2]}, {3'd3, 3'd3, 3'd7});
    lat <= 8'd1;
    // Timer edges do nothing while hardware triggering is off
    apb(1'b1, 12'h004, 32'h0);
    q.delete();
    pulse(6'h3f);
    repeat (300) @(posedge clk);
    cmp(q.size(), 0);
    // Each source code answers its own timer output and ignores the next one
    for (k = 1; k <= 6; k++) begin
      apb(1'b1, 12'h004, 32'h1 | (k << 1));
      q.delete();
      pulse(6'h01 << (k % 6));
      repeat (200) @(posedge clk);
      cmp(q.size(), 0);
      pulse(6'h01 << (k - 1));
      waitq(3);
    end
    // Sleep drops power when idle; without sleep power stays up
    apb(1'b1, 12'h004, 32'h00010020);
    go();
    // Eight warm-up periods of two clocks, less one clock of tick alignment
    k = 0;
    while (trackActive !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    cmp(k == 15 || k == 16, 1'b1);
    waitq(3);
    repeat (50) @(posedge clk);
    cmp(corePowerOn, 1'b0);
    apb(1'b1, 12'h004, 32'h0);
    go();
    waitq(3);
    repeat (50) @(posedge clk);
    cmp(corePowerOn, 1'b1);
    // Four single-channel triggers build one average of four samples
    apb(1'b1, 12'h014, 32'h0000000c);
    apb(1'b1, 12'h040, 32'h00010000);
    repeat (4) begin
      go();
      waitq(1);
    end
    repeat (20) @(posedge clk);
    rdc(12'h020, 32'h00000054);
    apb(1'b1, 12'h040, 32'h0);
    apb(1'b1, 12'h010, 32'h0000000c);
    // Free run with averaging off: clock period and tracking length
    q.delete();
    apb(1'b1, 12'h004, 32'h03000280);
    waitq(4);
    @(posedge convClk);
    t = $realtime;
    @(posedge convClk);
    cmp(int'(($realtime - t) / 50.0), 32'd6);
    @(posedge trackActive);
    k = 0;
    while (trackActive === 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    cmp(k, 32'd24);
    // Soft reset clears settings and stops free run
    apb(1'b1, 12'h000, 32'h1);
    rdc(12'h004, 32'h0);
    rdc(12'h018, 32'h0);
    q.delete();
    repeat (100) @(posedge clk);
    cmp(q.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
